// [rtl/lic_pkg.sv]
package lic_pkg;
    // ---------------------------------------------------------------
    // Delivery modes
    // ---------------------------------------------------------------
    localparam logic [2:0] DM_FIXED  = 3'h0;  // Fixed vector
    localparam logic [2:0] DM_LOWPRI = 3'h1;  // Lowest priority
    localparam logic [2:0] DM_SMI    = 3'h2;  // System management
    localparam logic [2:0] DM_RREAD  = 3'h3;  // Remote read
    localparam logic [2:0] DM_NMI    = 3'h4;  // Non-maskable
    localparam logic [2:0] DM_INIT   = 3'h5;  // Processor init
    localparam logic [2:0] DM_START  = 3'h6;  // Start-up
    localparam logic [2:0] DM_EXTINT = 3'h7;  // External vector

    // ---------------------------------------------------------------
    // Local vector table layout
    // ---------------------------------------------------------------
    localparam int         NUM_LVT   = 5;     // Entry count
    localparam int         LVT_LINT0 = 0;     // Pin input 0
    localparam int         LVT_LOCAL_INTERRUPT_INPUT_1 = 1;     // Pin input 1
    localparam int         LVT_PERF  = 2;     // Counter overflow
    localparam int         LVT_THERM = 3;     // Thermal sensor
    localparam int         LVT_ERR   = 4;     // Error entry
    localparam logic [4:0] MASK_ALL  = 5'h1f; // Every entry masked
    localparam logic [4:0] PEND_NONE = 5'h00; // Nothing pending

    // ---------------------------------------------------------------
    // Identifier and destination widths
    // ---------------------------------------------------------------
    localparam logic [7:0] ID_MASK_BASE = 8'h0f; // 4-bit identifier
    localparam logic [7:0] ID_MASK_EXT  = 8'hff; // 8-bit identifier
    localparam logic [7:0] DEST_BCAST   = 8'hff; // Physical broadcast
    localparam logic [3:0] CLU_BCAST    = 4'hf;  // All clusters
    localparam int         ESR_W        = 8;     // Error status width
    localparam logic [7:0] ESR_CLEAR    = 8'h00; // Cleared status

    // ---------------------------------------------------------------
    // Logical destination formats
    // ---------------------------------------------------------------
    localparam logic [1:0] FMT_FLAT     = 2'h0;  // Flat bit mask
    localparam logic [1:0] FMT_FLATCLU  = 2'h1;  // Flat cluster
    localparam logic [1:0] FMT_HIERCLU  = 2'h2;  // Hierarchical cluster

    // Message on the inter-controller bus
    typedef struct packed {
        logic [2:0] mode;     // Delivery mode
        logic [7:0] vector;   // Vector number
        logic       logical;  // Logical destination
        logic [7:0] dest;     // Destination field
        logic       level;    // Level triggered
        logic       assert_;  // Assert, low for deassert
    } lic_msg_t;

    // One local vector table entry, mask kept apart
    typedef struct packed {
        logic [2:0] mode;      // Delivery mode
        logic [7:0] vector;    // Vector number
        logic       level;     // Level triggered
        logic       activeLow; // Pin polarity
    } lic_lvt_t;

    // Signals toward the processor core
    typedef struct packed {
        logic       irq;          // Vectored request held
        logic [7:0] vector;       // Vector of held request
        logic       level;        // Held request is level
        logic       nmi;          // Non-maskable pulse
        logic       system_management_interrupt;          // System management pulse
        logic       init;         // Init pulse
        logic       initDeassert; // Init deassert pulse
        logic       startup;      // Start-up pulse
        logic [7:0] startVec;     // Start-up vector
    } lic_core_t;
endpackage : lic_pkg

// [rtl/lic_core.sv]
`timescale 1ns/10ps
// Notes on behaviour
// - Disable sets all table masks, keeps rest
// - Disabled: accept only init, SYSTEM_MANAGEMENT_INTERRUPT, NMI, start-up
// - NMI and init always edge, except deassert
// - Command messages go edge, except init deassert
// - Logical identifier is eight bits
// - Identifier four bits base, eight extended
// - Extended variant refuses remote read
// - Lowest priority: join only with free slot
// - Logical mode matches cluster addresses
// - Software switch for focus checking
// - Both pin inputs have programmable polarity
// - Commands may send system management messages
// - Error status logs errors, raises interrupt
// - Table entry for counter overflow interrupts
// - Extended variant has thermal entry
// - Extended variant has no focus delivery
// - Extended variant lacks flat cluster format
module lic_core #(
    parameter bit EXTENDED = 1'b0                       // Variant select
) (
    input  wire logic                         clk,
    input  wire logic                         rst,
    input  wire logic                         swEnable,      // Software enable flag
    input  wire lic_pkg::lic_lvt_t [4:0]      lvtCfg,        // Table entries
    input  wire logic                         lvtMaskWr,     // Mask write strobe
    input  wire logic [4:0]                   lvtMaskIn,     // Mask write data
    input  wire logic [7:0]                   localId,       // Controller identifier
    input  wire logic [7:0]                   logicalId,     // Logical identifier
    input  wire logic [1:0]                   destFmt,       // Logical format
    input  wire logic                         focusCheckEn,  // Focus checking on
    input  wire logic [1:0]                   lintPin,       // Pin inputs, async
    input  wire logic                         perfOverflow,  // Counter overflow event
    input  wire logic                         thermEvent,    // Thermal event
    input  wire logic [7:0]                   errIn,         // Error event bits
    input  wire logic                         esrClear,      // Clear error status
    input  wire logic                         coreAck,       // Core took held request
    input  wire logic                         msgValid,      // Inbound message strobe
    input  wire lic_pkg::lic_msg_t            msgIn,         // Inbound message
    input  wire logic                         arbDone,       // Arbitration result strobe
    input  wire logic                         arbWon,        // This unit won
    input  wire logic                         cmdValid,      // Command strobe
    input  wire lic_pkg::lic_msg_t            cmdIn,         // Command message
    output lic_pkg::lic_core_t                coreOut,       // Toward core
    output logic                              msgAck,        // Inbound accepted
    output logic                              msgNack,       // Inbound refused
    output logic                              arbJoin,       // Joins arbitration
    output logic                              focusClaim,    // Claimed as focus
    output logic                              rrValid,       // Remote read answer
    output logic [7:0]                        rrData,        // Remote read data
    output logic                              msgOutValid,   // Outbound strobe
    output lic_pkg::lic_msg_t                 msgOut,        // Outbound message
    output logic                              cmdRefused,    // Command dropped
    output logic [7:0]                        esrOut,        // Error status
    output logic [4:0]                        lvtMaskOut     // Current masks
);
    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    logic [1:0] pinMeta_r;   // First stage, read by second only
    logic [1:0] pinSync_r;   // Second stage
    logic [1:0] pinPrev_r;   // Previous active level
    logic [1:0] pinAct;      // Active level after polarity
    logic [1:0] pinMeta_nxt;
    logic [1:0] pinSync_nxt;
    logic [1:0] pinPrev_nxt;

    // Next values for the synchroniser group
    always_comb begin
        pinMeta_nxt = lintPin;
        pinSync_nxt = pinMeta_r;
        pinAct[0]   = pinSync_r[0] ^ lvtCfg[lic_pkg::LVT_LINT0].activeLow;
        pinAct[1]   = pinSync_r[1] ^ lvtCfg[lic_pkg::LVT_LOCAL_INTERRUPT_INPUT_1].activeLow;
        pinPrev_nxt = pinAct;
    end

    // Register the synchroniser group
    always_ff @(posedge clk) begin
        if (rst) begin
            pinMeta_r <= 2'h0;
            pinSync_r <= 2'h0;
            pinPrev_r <= 2'h0;
        end else begin
            pinMeta_r <= pinMeta_nxt;
            pinSync_r <= pinSync_nxt;
            pinPrev_r <= pinPrev_nxt;
        end
    end

    // ---------------------------------------------------------------
    // Helper functions
    // ---------------------------------------------------------------
    // Destination match, physical or logical
    function automatic logic destMatch(input lic_pkg::lic_msg_t m);
        logic [7:0] idMask;
        idMask = EXTENDED ? lic_pkg::ID_MASK_EXT : lic_pkg::ID_MASK_BASE;
        if (!m.logical) begin
            destMatch = (m.dest == lic_pkg::DEST_BCAST) || ((m.dest & idMask) == (localId & idMask));
        end else if (destFmt == lic_pkg::FMT_FLAT) begin
            destMatch = |(m.dest & logicalId);
        end else if (destFmt == lic_pkg::FMT_FLATCLU && EXTENDED) begin
            destMatch = 1'b0;
        end else begin
            destMatch = ((m.dest[7:4] == logicalId[7:4]) || (m.dest[7:4] == lic_pkg::CLU_BCAST))
                        && |(m.dest[3:0] & logicalId[3:0]);
        end
    endfunction : destMatch

    // Lowest numbered pending entry
    function automatic logic [2:0] firstPend(input logic [4:0] p);
        firstPend = 3'h0;
        for (int i = lic_pkg::NUM_LVT - 1; i >= 0; i--) begin
            if (p[i]) begin
                firstPend = 3'(i);
            end
        end
    endfunction : firstPend

    // ---------------------------------------------------------------
    // Main state
    // ---------------------------------------------------------------
    lic_pkg::lic_core_t core_r,    core_nxt;     // Core outputs
    lic_pkg::lic_msg_t  msgOut_r,  msgOut_nxt;   // Outbound message
    logic [4:0]         mask_r,    mask_nxt;     // Table masks
    logic [4:0]         pend_r,    pend_nxt;     // Pending local events
    logic [7:0]         esr_r,     esr_nxt;      // Error status
    logic               lpHeld_r,  lpHeld_nxt;   // Lowest priority waiting
    logic [7:0]         lpVec_r,   lpVec_nxt;    // Its vector
    logic               ack_r,     ack_nxt;
    logic               nack_r,    nack_nxt;
    logic               join_r,    join_nxt;
    logic               focus_r,   focus_nxt;
    logic               rrv_r,     rrv_nxt;
    logic [7:0]         rrd_r,     rrd_nxt;
    logic               mov_r,     mov_nxt;
    logic               refuse_r,  refuse_nxt;
    logic [4:0]         events;                  // Local events this cycle
    logic [2:0]         sel;                     // Entry being served
    lic_pkg::lic_lvt_t  selCfg;                  // Its configuration
    logic               msgOk;                   // Message addressed and allowed

    // Next values for the main group
    always_comb begin
        core_nxt   = core_r;
        msgOut_nxt = msgOut_r;
        lpHeld_nxt = lpHeld_r;
        lpVec_nxt  = lpVec_r;
        ack_nxt    = 1'b0;
        nack_nxt   = 1'b0;
        join_nxt   = 1'b0;
        focus_nxt  = 1'b0;
        rrv_nxt    = 1'b0;
        rrd_nxt    = rrd_r;
        mov_nxt    = 1'b0;
        refuse_nxt = 1'b0;
        core_nxt.nmi          = 1'b0;
        core_nxt.system_management_interrupt          = 1'b0;
        core_nxt.init         = 1'b0;
        core_nxt.initDeassert = 1'b0;
        core_nxt.startup      = 1'b0;
        if (coreAck) begin
            core_nxt.irq = 1'b0;
        end

        // Masks: software writes, forced set while disabled
        mask_nxt = lvtMaskWr ? lvtMaskIn : mask_r;
        if (!swEnable) begin
            mask_nxt = lic_pkg::MASK_ALL;
        end

        // Error status, new error wins over clear
        esr_nxt = esrClear ? lic_pkg::ESR_CLEAR : esr_r;
        esr_nxt = esr_nxt | errIn;

        // Local events; level pins in fixed mode re-pend while active
        events = lic_pkg::PEND_NONE;
        for (int i = 0; i < 2; i++) begin
            events[i] = (lvtCfg[i].level && lvtCfg[i].mode == lic_pkg::DM_FIXED) ? pinAct[i]
                        : (pinAct[i] && !pinPrev_r[i]);
        end
        events[lic_pkg::LVT_PERF]  = perfOverflow;
        events[lic_pkg::LVT_THERM] = EXTENDED && thermEvent;
        events[lic_pkg::LVT_ERR]   = |(errIn & ~esr_r);
        pend_nxt = (pend_r | events) & ~mask_r;

        // Serve one local entry
        sel    = firstPend(pend_nxt);
        selCfg = lvtCfg[sel];
        if (pend_nxt != lic_pkg::PEND_NONE) begin
            unique case (selCfg.mode)
                lic_pkg::DM_NMI: begin
                    core_nxt.nmi  = 1'b1;
                    pend_nxt[sel] = 1'b0;
                end
                lic_pkg::DM_SMI: begin
                    core_nxt.system_management_interrupt  = 1'b1;
                    pend_nxt[sel] = 1'b0;
                end
                lic_pkg::DM_INIT: begin
                    core_nxt.init = 1'b1;
                    pend_nxt[sel] = 1'b0;
                end
                default: begin
                    if (!core_nxt.irq) begin
                        core_nxt.irq    = 1'b1;
                        core_nxt.vector = selCfg.vector;
                        core_nxt.level  = selCfg.level && selCfg.mode == lic_pkg::DM_FIXED;
                        pend_nxt[sel]   = 1'b0;
                    end
                end
            endcase
        end

        // Arbitration result for a held lowest priority request
        if (arbDone && lpHeld_r) begin
            lpHeld_nxt = 1'b0;
            if (arbWon && !core_nxt.irq) begin
                core_nxt.irq    = 1'b1;
                core_nxt.vector = lpVec_r;
                core_nxt.level  = 1'b0;
            end
        end

        // Inbound message
        msgOk = msgValid && destMatch(msgIn) && (swEnable || msgIn.mode == lic_pkg::DM_INIT
                || msgIn.mode == lic_pkg::DM_SMI || msgIn.mode == lic_pkg::DM_NMI
                || msgIn.mode == lic_pkg::DM_START);
        if (msgValid && destMatch(msgIn) && !msgOk) begin
            nack_nxt = 1'b1;
        end
        if (msgOk) begin
            ack_nxt = 1'b1;
            unique case (msgIn.mode)
                lic_pkg::DM_LOWPRI: begin
                    if (!EXTENDED && focusCheckEn && core_r.irq && core_r.vector == msgIn.vector) begin
                        focus_nxt = 1'b1;
                    end else if (!core_nxt.irq && !lpHeld_nxt) begin
                        join_nxt   = 1'b1;
                        lpHeld_nxt = 1'b1;
                        lpVec_nxt  = msgIn.vector;
                    end else begin
                        ack_nxt  = 1'b0;
                        nack_nxt = 1'b1;
                    end
                end
                lic_pkg::DM_RREAD: begin
                    if (EXTENDED) begin
                        ack_nxt  = 1'b0;
                        nack_nxt = 1'b1;
                    end else begin
                        rrv_nxt = 1'b1;
                        rrd_nxt = logicalId;
                    end
                end
                lic_pkg::DM_NMI: begin
                    core_nxt.nmi = 1'b1;
                end
                lic_pkg::DM_SMI: begin
                    core_nxt.system_management_interrupt = 1'b1;
                end
                lic_pkg::DM_INIT: begin
                    if (msgIn.level && !msgIn.assert_) begin
                        core_nxt.initDeassert = 1'b1;
                    end else begin
                        core_nxt.init = 1'b1;
                    end
                end
                lic_pkg::DM_START: begin
                    core_nxt.startup  = 1'b1;
                    core_nxt.startVec = msgIn.vector;
                end
                default: begin
                    if (!core_nxt.irq) begin
                        core_nxt.irq    = 1'b1;
                        core_nxt.vector = msgIn.vector;
                        core_nxt.level  = msgIn.level;
                    end else begin
                        ack_nxt  = 1'b0;
                        nack_nxt = 1'b1;
                    end
                end
            endcase
        end

        // Outbound command, including system management
        if (cmdValid) begin
            if (EXTENDED && cmdIn.mode == lic_pkg::DM_RREAD) begin
                refuse_nxt = 1'b1;
            end else begin
                mov_nxt          = 1'b1;
                msgOut_nxt       = cmdIn;
                msgOut_nxt.level = cmdIn.mode == lic_pkg::DM_INIT && !cmdIn.assert_;
            end
        end
    end

    // Register the main group
    always_ff @(posedge clk) begin
        if (rst) begin
            core_r   <= '0;
            msgOut_r <= '0;
            mask_r   <= lic_pkg::MASK_ALL;
            pend_r   <= lic_pkg::PEND_NONE;
            esr_r    <= lic_pkg::ESR_CLEAR;
            lpHeld_r <= 1'b0;
            lpVec_r  <= 8'h00;
            ack_r    <= 1'b0;
            nack_r   <= 1'b0;
            join_r   <= 1'b0;
            focus_r  <= 1'b0;
            rrv_r    <= 1'b0;
            rrd_r    <= 8'h00;
            mov_r    <= 1'b0;
            refuse_r <= 1'b0;
        end else begin
            core_r   <= core_nxt;
            msgOut_r <= msgOut_nxt;
            mask_r   <= mask_nxt;
            pend_r   <= pend_nxt;
            esr_r    <= esr_nxt;
            lpHeld_r <= lpHeld_nxt;
            lpVec_r  <= lpVec_nxt;
            ack_r    <= ack_nxt;
            nack_r   <= nack_nxt;
            join_r   <= join_nxt;
            focus_r  <= focus_nxt;
            rrv_r    <= rrv_nxt;
            rrd_r    <= rrd_nxt;
            mov_r    <= mov_nxt;
            refuse_r <= refuse_nxt;
        end
    end

    // ---------------------------------------------------------------
    // Outputs, all from flip-flops
    // ---------------------------------------------------------------
    assign coreOut     = core_r;
    assign msgAck      = ack_r;
    assign msgNack     = nack_r;
    assign arbJoin     = join_r;
    assign focusClaim  = focus_r;
    assign rrValid     = rrv_r;
    assign rrData      = rrd_r;
    assign msgOutValid = mov_r;
    assign msgOut      = msgOut_r;
    assign cmdRefused  = refuse_r;
    assign esrOut      = esr_r;
    assign lvtMaskOut  = mask_r;
endmodule : lic_core

// [tb/lic_core_props.sv]
`timescale 1ns/10ps
// Port-level checks on message, command and error behaviour
module lic_core_props #(
    parameter bit EXTENDED = 1'b0
) (
    input wire logic               clk,
    input wire logic               rst,
    input wire logic               swEnable,
    input wire logic [7:0]         errIn,
    input wire logic               coreAck,
    input wire logic               msgValid,
    input wire lic_pkg::lic_msg_t  msgIn,
    input wire logic               cmdValid,
    input wire lic_pkg::lic_msg_t  cmdIn,
    input wire lic_pkg::lic_core_t coreOut,
    input wire logic               msgAck,
    input wire logic               arbJoin,
    input wire logic               focusClaim,
    input wire logic               msgOutValid,
    input wire lic_pkg::lic_msg_t  msgOut,
    input wire logic               cmdRefused,
    input wire logic [7:0]         esrOut,
    input wire logic [4:0]         lvtMaskOut
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_mask_when_off: assert property (!swEnable |=> lvtMaskOut == lic_pkg::MASK_ALL)
        else $error("masks not all set while disabled");
    a_disabled_refuse: assert property (msgValid && !swEnable && !(msgIn.mode inside {3'h2, 3'h4, 3'h5, 3'h6})
        |=> !msgAck) else $error("message taken while disabled");
    a_cmd_edge_only: assert property (cmdValid && !(cmdIn.mode == 3'h5 && !cmdIn.assert_)
        |=> !msgOutValid || !msgOut.level) else $error("command sent as level");
    a_deassert_level: assert property (cmdValid && cmdIn.mode == 3'h5 && !cmdIn.assert_
        |=> msgOutValid && msgOut.level) else $error("init deassert not sent as level");
    a_smi_command: assert property (cmdValid && cmdIn.mode == lic_pkg::DM_SMI
        |=> msgOutValid && msgOut.mode == lic_pkg::DM_SMI) else $error("management command not sent");
    a_rread_refused: assert property (EXTENDED && cmdValid && cmdIn.mode == lic_pkg::DM_RREAD
        |=> cmdRefused && !msgOutValid) else $error("remote read sent in extended unit");
    a_esr_logs: assert property (errIn != 8'h00 |=> (esrOut & $past(errIn)) == $past(errIn))
        else $error("error bit not logged");
    a_busy_no_join: assert property (msgValid && msgIn.mode == lic_pkg::DM_LOWPRI && coreOut.irq && !coreAck
        |=> !arbJoin) else $error("joined arbitration with slot held");
    a_no_focus_ext: assert property (EXTENDED && msgValid |=> !focusClaim)
        else $error("focus claimed in extended unit");
endmodule : lic_core_props

bind lic_core lic_core_props #(.EXTENDED(EXTENDED)) i_props (.*);

// [tb/lic_core_peer.sv]
`timescale 1ns/10ps
// Core stand-in: takes a held request after a short fixed wait
module lic_core_peer (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire lic_pkg::lic_core_t coreOut,
    output logic                    coreAck
);
    logic [2:0] heldCnt_r;  // Edges the request has stood
    always_ff @(posedge clk) begin
        if (rst || !coreOut.irq || coreAck) begin
            heldCnt_r <= 3'h0;
            coreAck   <= 1'b0;
        end else begin
            heldCnt_r <= heldCnt_r + 3'h1;
            coreAck   <= (heldCnt_r == 3'h6);
        end
    end
endmodule : lic_core_peer

// [tb/test_lic_core.sv]
`timescale 1ns/10ps
// Base and extended units see the same stimulus
module test_lic_core;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic swEnable, lvtMaskWr, focusCheckEn, perfOverflow, thermEvent, esrClear, coreAck, coreAckX;
    logic msgValid, arbDone, arbWon, cmdValid, msgAck, msgNack, arbJoin, focusClaim, rrValid;
    logic msgOutValid, cmdRefused, ackX, nackX, refX;
    logic [7:0] localId, logicalId, errIn, rrData, esrOut;
    logic [4:0] lvtMaskIn, lvtMaskOut;
    logic [1:0] destFmt, lintPin;
    lic_pkg::lic_lvt_t [4:0] lvtCfg;
    lic_pkg::lic_msg_t msgIn, cmdIn, msgOut;
    lic_pkg::lic_core_t coreOut, coreOutX;
    int error_cnt = 0;
    int cmp_count = 0;
    always #20 clk = ~clk;
    lic_core #(.EXTENDED(1'b0)) i_dut (.*);
    lic_core #(.EXTENDED(1'b1)) i_ext (.*, .coreAck(coreAckX), .coreOut(coreOutX), .msgAck(ackX), .msgNack(nackX),
        .arbJoin(), .focusClaim(), .rrValid(), .rrData(), .msgOutValid(), .msgOut(), .cmdRefused(refX),
        .esrOut(), .lvtMaskOut());
    lic_core_peer i_core (.clk(clk), .rst(rst), .coreOut(coreOut), .coreAck(coreAck));
    lic_core_peer i_coreX (.clk(clk), .rst(rst), .coreOut(coreOutX), .coreAck(coreAckX));
    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    // Bounded wait for the held request to reach a level
    task automatic waitFor(input logic want);
        for (int i = 0; i < 24 && coreOut.irq !== want; i++) tick(1);
        if (coreOut.irq !== want) begin
            error_cnt++;
            $display("[FAIL] %0t request wait ran out", $time);
            stop_test;
        end
    endtask : waitFor
    function automatic lic_pkg::lic_msg_t mk(input logic [2:0] mode, input logic [7:0] dest, input logic asrt);
        mk = '{mode, 8'h40, 1'b0, dest, 1'b1, asrt};
    endfunction : mk
    // Message or command strobe; answer is read just after the edge that takes it
    task automatic send(input lic_pkg::lic_msg_t m, input logic isCmd);
        @(posedge clk);
        msgValid <= !isCmd;
        cmdValid <= isCmd;
        msgIn    <= m;
        cmdIn    <= m;
        @(posedge clk);
        msgValid <= 1'b0;
        cmdValid <= 1'b0;
        #1;
    endtask : send
    task automatic pulse(input int which);
        @(posedge clk);
        {errIn, thermEvent, perfOverflow, arbDone, arbWon} <= {which == 2 ? 8'h11 : 8'h00, which == 1, which == 0,
            which == 3, which == 3};
        @(posedge clk);
        {errIn, thermEvent, perfOverflow, arbDone, arbWon} <= '0;
    endtask : pulse
    task automatic t_local;
        for (int p = 0; p < 2; p++) begin
            waitFor(1'b0);
            @(posedge clk);
            lintPin <= p ? 2'b11 : 2'b00;
            tick(4);
            chk({coreOut.irq, coreOut.vector}, p ? 9'h151 : 9'h150);
            lintPin <= 2'b01;
        end
        waitFor(1'b0);
        pulse(0);
        waitFor(1'b1);
        chk(coreOut.vector, 8'h52);
        waitFor(1'b0);
        pulse(1);
        tick(4);
        chk({coreOut.irq, coreOutX.irq, coreOutX.vector}, 10'h153);
        pulse(2);
        waitFor(1'b1);
        chk({coreOut.vector, esrOut}, 16'h5411);
        @(posedge clk);
        esrClear <= 1'b1;
        @(posedge clk);
        esrClear <= 1'b0;
        tick(1);
        chk(esrOut, 8'h00);
        $display("local source test done");
    endtask : t_local
    task automatic t_lowpri;
        waitFor(1'b0);
        send(mk(lic_pkg::DM_FIXED, 8'h13, 1'b1), 1'b0);
        chk({msgAck, ackX, nackX}, 3'h4);
        send(mk(lic_pkg::DM_LOWPRI, 8'h03, 1'b1), 1'b0);
        chk({msgNack, arbJoin}, 2'h2);
        focusCheckEn <= 1'b1;
        send(mk(lic_pkg::DM_LOWPRI, 8'h03, 1'b1), 1'b0);
        chk({msgAck, focusClaim, nackX}, 3'h7);
        waitFor(1'b0);
        send(mk(lic_pkg::DM_LOWPRI, 8'h03, 1'b1), 1'b0);
        chk({msgAck, arbJoin}, 2'h3);
        pulse(3);
        tick(1);
        chk({coreOut.irq, coreOut.vector}, 9'h140);
        $display("lowest priority test done");
    endtask : t_lowpri
    task automatic t_cmd;
        for (int k = 0; k < 16; k++) begin
            send(mk(k[2:0], 8'h05, k[3]), 1'b1);
            chk({msgOutValid, msgOut.mode}, {1'b1, k[2:0]});
            chk(msgOut.level, k[2:0] == 3'h5 && !k[3]);
            chk(refX, k[2:0] == 3'h3);
        end
        $display("command test done");
    endtask : t_cmd
    task automatic t_route;
        @(posedge clk) destFmt <= 2'h2;
        send('{3'h3, 8'h40, 1'b1, 8'hf1, 1'b1, 1'b1}, 1'b0);
        chk({rrValid, rrData, msgAck, nackX}, 11'h407);
        @(posedge clk) destFmt <= 2'h1;
        send('{3'h3, 8'h40, 1'b1, 8'h01, 1'b1, 1'b1}, 1'b0);
        chk({rrValid, ackX, nackX}, 3'h4);
        @(posedge clk) destFmt <= 2'h0;
        send('{3'h5, 8'h40, 1'b1, 8'h02, 1'b1, 1'b0}, 1'b0);
        chk({msgAck, msgNack}, 2'h0);
        send('{3'h5, 8'h40, 1'b1, 8'h01, 1'b1, 1'b0}, 1'b0);
        chk({coreOut.initDeassert, coreOut.init, msgAck}, 3'h5);
        $display("routing test done");
    endtask : t_route
    task automatic t_disable;
        waitFor(1'b0);
        swEnable <= 1'b0;
        tick(2);
        chk(lvtMaskOut, lic_pkg::MASK_ALL);
        for (int k = 0; k < 8; k++) begin
            send(mk(k[2:0], 8'h03, 1'b1), 1'b0);
            chk({msgAck, msgNack}, k inside {2, 4, 5, 6} ? 2'h2 : 2'h1);
            chk({coreOut.nmi, coreOut.system_management_interrupt, coreOut.init, coreOut.startup}, {k == 4, k == 2, k == 5, k == 6});
            tick(1);
            chk(coreOut.nmi | coreOut.init, 1'b0);
        end
        $display("disable test done");
    endtask : t_disable
    initial begin
        {swEnable, localId, logicalId, destFmt, lintPin} = {1'b1, 8'h03, 8'h01, 2'h0, 2'b01};
        {lvtMaskWr, lvtMaskIn, focusCheckEn, esrClear, msgValid, cmdValid} = '0;
        {errIn, thermEvent, perfOverflow, arbDone, arbWon} = '0;
        {msgIn, cmdIn} = '0;
        for (int i = 0; i < 5; i++) lvtCfg[i] = '{3'h0, 8'h50 + 8'(i), 1'b0, i == 0};
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        {lvtMaskWr, lvtMaskIn} <= 6'h20;
        @(posedge clk);
        lvtMaskWr <= 1'b0;
        t_local;
        t_lowpri;
        t_cmd;
        t_route;
        t_disable;
        stop_test;
    end
endmodule : test_lic_core
